// file: verilog/abm_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "abm_defines.svh"

// Overview of operation
// [R1] Gain numerator from gain code and reference
// [R2] Span per gain code, reference independent
// [R3] Coarse offset signed from offset field
// [R4] Host picks supply reference by voltage
// [R5] Sensor on when selected or tested
// [R6] Host temperature read sequence
// [R7] Offset enabled ranges and steps
// [R8] Offset disabled range 10 is kelvin
// [R9] Host converts code times step plus low
// [R10] Temperature control resets to 20h
// [R11] Trim applied when trim enable set
// [R12] Monitor runs only when enable set
// [R13] Five-bit threshold, reset 14h
// [R14] Level register, five bits, top zero
// [R15] Level code is 1.7 V plus 50 mV
// [R16] Measure once per second for 250 us
// [R17] Four low readings before an event
// [R18] Interrupt pin only when enabled
// [R19] Host reads both status registers
// [R20] Oscillator started when monitor enabled asleep
// [R21] Low run restarts on high reading
module abm_top
  import abm_pkg::*;
#(
  parameter int PERIOD_CYC = `ABM_PERIOD_CYC,
  parameter int PERIOD_TICKS = `ABM_PERIOD_TICKS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Serial register port
  input wire logic spi_sck_i,
  input wire logic spi_sdi_i,
  input wire logic spi_sel_n_i,
  output logic spi_sdo_o,
  // Interrupt to the host
  output logic irq_out_n_o,
  // Module state and analog side
  input wire logic sleep_i,
  input wire logic rc_tick_i,
  input wire logic atest_temp_i,
  input wire logic [7:0] adc_value_i,
  input wire logic [4:0] vbat_code_i,
  // Front end controls
  output abm_analog_t analog_o,
  output logic [7:0] tv_offs_o,
  output logic rc_en_o,
  output logic meas_en_o
);

  // Register state
  abm_adc_cfg_t adc_cfg_q, adc_cfg_d;
  logic [3:0] adc_offs_q, adc_offs_d;
  abm_ts_ctrl_t ts_ctrl_q, ts_ctrl_d;
  logic [7:0] tv_offs_q, tv_offs_d;
  logic [4:0] thresh_q, thresh_d;
  logic [4:0] level_q, level_d;
  logic mon_en_q, mon_en_d;
  logic mon_ie_q, mon_ie_d;
  logic mon_flag_q, mon_flag_d;
  abm_analog_t analog_q, analog_d;

  // Serial port state
  abm_spi_state_t spi_st_q, spi_st_d;
  logic sck_q, sck_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic [6:0] addr_q, addr_d;
  logic wr_q, wr_d;
  logic [7:0] tx_q, tx_d;

  logic sck_rise;
  logic sck_fall;
  logic [7:0] sh_in;
  logic wr_stb;
  logic rd_stb;
  logic [6:0] rd_addr;
  logic sample;
  logic low_event;

  // Read data for one address; unmapped and reserved bits read zero
  function automatic logic [7:0] reg_read(input logic [6:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `ABM_OFF_STATUS2: v[`ABM_BIT_MON_STATUS] = mon_flag_q;
      `ABM_OFF_IRQ_EN2: v[`ABM_BIT_MON_IRQ_EN] = mon_ie_q;
      `ABM_OFF_OPMODE1: v[`ABM_BIT_MON_EN] = mon_en_q;
      `ABM_OFF_ADC_CFG: v = {1'b0, adc_cfg_q};
      `ABM_OFF_ADC_OFFS: v = {4'h0, adc_offs_q};
      `ABM_OFF_ADC_VALUE: v = adc_value_i;
      `ABM_OFF_TS_CTRL: v = ts_ctrl_q;
      `ABM_OFF_TV_OFFS: v = tv_offs_q;
      `ABM_OFF_BAT_THRESH: v = {3'h0, thresh_q};
      `ABM_OFF_BAT_LEVEL: v = {3'h0, level_q}; // [R14]
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Pins are synchronous, so the previous clock level gives the edges
  assign sck_rise = !spi_sel_n_i && spi_sck_i && !sck_q;
  assign sck_fall = !spi_sel_n_i && !spi_sck_i && sck_q;
  assign sh_in = {sh_q[6:0], spi_sdi_i};

  // Frame: write flag and address, then one data byte, MSB first
  always_comb begin
    spi_st_d = spi_st_q;
    sck_d = spi_sck_i;
    bit_d = bit_q;
    sh_d = sh_q;
    addr_d = addr_q;
    wr_d = wr_q;
    tx_d = tx_q;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    rd_addr = sh_in[6:0];
    case (spi_st_q)
      ABM_SPI_IDLE: begin
        bit_d = 4'h0;
        if (!spi_sel_n_i) begin
          spi_st_d = ABM_SPI_ADDR;
        end
      end
      ABM_SPI_ADDR: begin
        if (sck_rise) begin
          sh_d = sh_in;
          bit_d = bit_q + 4'h1;
          if (bit_q == 4'h7) begin
            wr_d = sh_in[7];
            addr_d = sh_in[6:0];
            bit_d = 4'h0;
            spi_st_d = ABM_SPI_DATA;
            if (!sh_in[7]) begin
              rd_stb = 1'b1;
              tx_d = reg_read(sh_in[6:0]);
            end
          end
        end
      end
      ABM_SPI_DATA: begin
        if (sck_rise) begin
          sh_d = sh_in;
          bit_d = bit_q + 4'h1;
          if (bit_q == 4'h7) begin
            wr_stb = wr_q;
            spi_st_d = ABM_SPI_IDLE; // End of the data byte; a select held low starts a new command byte
          end
        end else if (sck_fall && (bit_q != 4'h0)) begin
          tx_d = {tx_q[6:0], 1'b0};
        end
      end
      default: spi_st_d = ABM_SPI_IDLE;
    endcase
    if (spi_sel_n_i) begin
      spi_st_d = ABM_SPI_IDLE;
      tx_d = 8'h00;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      spi_st_q <= ABM_SPI_IDLE;
      sck_q <= 1'b0;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      addr_q <= 7'h00;
      wr_q <= 1'b0;
      tx_q <= 8'h00;
    end else begin
      spi_st_q <= spi_st_d;
      sck_q <= sck_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      addr_q <= addr_d;
      wr_q <= wr_d;
      tx_q <= tx_d;
    end
  end

  assign spi_sdo_o = tx_q[7];

  // Register writes, level capture and the sticky low battery flag
  always_comb begin
    adc_cfg_d = adc_cfg_q;
    adc_offs_d = adc_offs_q;
    ts_ctrl_d = ts_ctrl_q;
    tv_offs_d = tv_offs_q;
    thresh_d = thresh_q;
    level_d = level_q;
    mon_en_d = mon_en_q;
    mon_ie_d = mon_ie_q;
    mon_flag_d = mon_flag_q;
    if (wr_stb) begin
      case (addr_q)
        `ABM_OFF_IRQ_EN2: mon_ie_d = sh_d[`ABM_BIT_MON_IRQ_EN];
        `ABM_OFF_OPMODE1: mon_en_d = sh_d[`ABM_BIT_MON_EN];
        `ABM_OFF_ADC_CFG: adc_cfg_d = sh_d[6:0]; // Start bit handled elsewhere
        `ABM_OFF_ADC_OFFS: adc_offs_d = sh_d[3:0];
        `ABM_OFF_TS_CTRL: ts_ctrl_d = sh_d; // [R10]
        `ABM_OFF_TV_OFFS: tv_offs_d = sh_d;
        `ABM_OFF_BAT_THRESH: thresh_d = sh_d[4:0]; // [R13]
        default: ;
      endcase
    end
    // Code is the converter's own 1.7 V plus 50 mV steps, kept as is
    if (sample) begin
      level_d = vbat_code_i; // [R14] [R15]
    end
    // Reading status clears the flag, but a same-cycle event wins
    if (rd_stb && (rd_addr == `ABM_OFF_STATUS2)) begin
      mon_flag_d = 1'b0;
    end
    if (low_event) begin
      mon_flag_d = 1'b1; // [R17]
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      adc_cfg_q <= `ABM_RST_ADC_CFG;
      adc_offs_q <= `ABM_RST_ADC_OFFS;
      ts_ctrl_q <= `ABM_RST_TS_CTRL; // [R10]
      tv_offs_q <= `ABM_RST_TV_OFFS;
      thresh_q <= `ABM_RST_BAT_THRESH; // [R13]
      level_q <= 5'h00;
      mon_en_q <= 1'b0;
      mon_ie_q <= 1'b0;
      mon_flag_q <= 1'b0;
    end else begin
      adc_cfg_q <= adc_cfg_d;
      adc_offs_q <= adc_offs_d;
      ts_ctrl_q <= ts_ctrl_d;
      tv_offs_q <= tv_offs_d;
      thresh_q <= thresh_d;
      level_q <= level_d;
      mon_en_q <= mon_en_d;
      mon_ie_q <= mon_ie_d;
      mon_flag_q <= mon_flag_d;
    end
  end

  // Front end settings; registered so the analog side sees clean levels
  always_comb begin
    logic [7:0] step;
    step = adc_cfg_q.refsel[0] ? `ABM_GAIN_STEP_REF1 : `ABM_GAIN_STEP_REF0;
    analog_d = '0;
    analog_d.gain_num = 8'(step * (8'(adc_cfg_q.gain) + 8'h01)); // [R1]
    case (adc_cfg_q.gain) // Gain tracks the reference, so span does not
      2'h0: analog_d.span_x10 = `ABM_SPAN_G0; // [R2]
      2'h1: analog_d.span_x10 = `ABM_SPAN_G1; // [R2]
      2'h2: analog_d.span_x10 = `ABM_SPAN_G2; // [R2]
      default: analog_d.span_x10 = `ABM_SPAN_G3; // [R2]
    endcase
    // Negative case -(8 - low) is exactly low - 8 in four-bit two's complement
    if (adc_offs_q[3]) begin
      analog_d.offs_steps = {1'b0, adc_offs_q[2:0]}; // [R3]
    end else if (adc_offs_q[2:0] != 3'h0) begin
      analog_d.offs_steps = {1'b1, adc_offs_q[2:0]}; // [R3]
    end else begin
      analog_d.offs_steps = 4'h0; // [R3]
    end
    analog_d.ts_en = (adc_cfg_q.sel == `ABM_SEL_TEMP) || atest_temp_i; // [R5]
    analog_d.ts_valid = 1'b1;
    if (ts_ctrl_q.offs_en) begin
      case (ts_ctrl_q.range)
        2'h0: begin
          analog_d.ts_lsb_milli = `ABM_TS_LSB_HALF; // [R7]
          analog_d.ts_low = `ABM_TS_LOW_M64;
        end
        2'h1: begin
          analog_d.ts_lsb_milli = `ABM_TS_LSB_ONE; // [R7]
          analog_d.ts_low = `ABM_TS_LOW_M64;
        end
        2'h2: begin
          analog_d.ts_lsb_milli = `ABM_TS_LSB_HALF; // [R7]
          analog_d.ts_low = `ABM_TS_LOW_ZERO;
        end
        default: begin
          analog_d.ts_lsb_milli = `ABM_TS_LSB_ONE; // [R7]
          analog_d.ts_low = `ABM_TS_LOW_M40;
          analog_d.ts_fahrenheit = 1'b1;
        end
      endcase
    end else if (ts_ctrl_q.range == 2'h2) begin
      analog_d.ts_absolute = 1'b1; // [R8]
      analog_d.ts_lsb_milli = `ABM_TS_LSB_KELVIN;
      analog_d.ts_low = `ABM_TS_LOW_ZERO;
    end else begin
      analog_d.ts_valid = 1'b0; // No defined scale without the offset
    end
    analog_d.vbg_trim_en = ts_ctrl_q.trim_en; // [R11]
    analog_d.vbg_trim = ts_ctrl_q.trim_en ? ts_ctrl_q.trim : 4'h0; // [R11]
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      analog_q <= '0;
    end else begin
      analog_q <= analog_d;
    end
  end

  assign analog_o = analog_q;
  assign tv_offs_o = tv_offs_q;

  // Periodic measurement window, only while the monitor is enabled
  abm_meas_timer #(
    .PERIOD_CYC(PERIOD_CYC),
    .PERIOD_TICKS(PERIOD_TICKS)
  ) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(mon_en_q), // [R12]
    .sleep_i(sleep_i),
    .rc_tick_i(rc_tick_i),
    .rc_en_o(rc_en_o),
    .meas_en_o(meas_en_o),
    .sample_o(sample)
  );

  // Run-length filter on readings below threshold
  abm_debounce u_debounce (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(mon_en_q), // [R12]
    .sample_i(sample),
    .below_i(vbat_code_i < thresh_q),
    .event_o(low_event)
  );

  // Pin pulled low while the flag stands and its enable is set
  assign irq_out_n_o = !(mon_flag_q && mon_ie_q); // [R18]

endmodule // abm_top

`default_nettype wire

// file: verilog/abm_defines.svh
`ifndef ABM_DEFINES_SVH
`define ABM_DEFINES_SVH

// Register offsets, 7-bit address space
`define ABM_OFF_STATUS1 7'h03
`define ABM_OFF_STATUS2 7'h04
`define ABM_OFF_IRQ_EN2 7'h06
`define ABM_OFF_OPMODE1 7'h07
`define ABM_OFF_ADC_CFG 7'h0f
`define ABM_OFF_ADC_OFFS 7'h10
`define ABM_OFF_ADC_VALUE 7'h11
`define ABM_OFF_TS_CTRL 7'h12
`define ABM_OFF_TV_OFFS 7'h13
`define ABM_OFF_BAT_THRESH 7'h1a
`define ABM_OFF_BAT_LEVEL 7'h1b

// Field positions
`define ABM_BIT_MON_IRQ_EN 2
`define ABM_BIT_MON_STATUS 2
`define ABM_BIT_MON_EN 6

// Reset values
`define ABM_RST_TS_CTRL 8'h20
`define ABM_RST_TV_OFFS 8'h00
`define ABM_RST_BAT_THRESH 5'h14
`define ABM_RST_ADC_CFG 7'h00
`define ABM_RST_ADC_OFFS 4'h0

// Amplifier gain steps, numerator over a fixed 13
`define ABM_GAIN_DEN 8'h0d
`define ABM_GAIN_STEP_REF0 8'h16
`define ABM_GAIN_STEP_REF1 8'h21
// Differential span in tenths of a percent of supply
`define ABM_SPAN_G0 8'ha7
`define ABM_SPAN_G1 8'h54
`define ABM_SPAN_G2 8'h38
`define ABM_SPAN_G3 8'h2a
// Coarse offset step in hundredths of a percent of supply
`define ABM_OFFS_STEP_X100 8'h0c
// Temperature sensor input select code
`define ABM_SEL_TEMP 3'h0
// Temperature step in thousandths of a degree, low end in degrees
`define ABM_TS_LSB_HALF 11'h1f4
`define ABM_TS_LSB_ONE 11'h3e8
`define ABM_TS_LSB_KELVIN 11'h535
`define ABM_TS_LOW_M64 9'h1c0
`define ABM_TS_LOW_M40 9'h1d8
`define ABM_TS_LOW_ZERO 9'h000

// Battery measurement timing
`define ABM_CLK_HZ 10000000
`define ABM_RC_HZ 32768
`define ABM_PERIOD_MS 1000
`define ABM_WINDOW_US 250
`define ABM_PERIOD_CYC (`ABM_PERIOD_MS * (`ABM_CLK_HZ / 1000))
`define ABM_WINDOW_CYC (`ABM_WINDOW_US * (`ABM_CLK_HZ / 1000000))
`define ABM_PERIOD_TICKS (`ABM_PERIOD_MS * `ABM_RC_HZ / 1000)
`define ABM_WINDOW_TICKS (`ABM_WINDOW_US * `ABM_RC_HZ / 1000000)
// Readings below threshold needed before an event
`define ABM_LOW_COUNT 3'h4

`endif

// file: verilog/abm_pkg.sv
package abm_pkg;

  // Converter configuration fields
  typedef struct packed {
    logic [2:0] sel;
    logic [1:0] refsel;
    logic [1:0] gain;
  } abm_adc_cfg_t;

  // Temperature sensor control fields
  typedef struct packed {
    logic [1:0] range;
    logic offs_en;
    logic trim_en;
    logic [3:0] trim;
  } abm_ts_ctrl_t;

  // Settings driven into the analog front end
  typedef struct packed {
    logic [7:0] gain_num;
    logic [7:0] span_x10;
    logic [3:0] offs_steps;
    logic ts_en;
    logic ts_valid;
    logic ts_fahrenheit;
    logic ts_absolute;
    logic [10:0] ts_lsb_milli;
    logic [8:0] ts_low;
    logic vbg_trim_en;
    logic [3:0] vbg_trim;
  } abm_analog_t;

  typedef enum logic [1:0] {
    ABM_SPI_IDLE,
    ABM_SPI_ADDR,
    ABM_SPI_DATA
  } abm_spi_state_t;

endpackage : abm_pkg

// file: verilog/abm_meas_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "abm_defines.svh"

module abm_meas_timer
  import abm_pkg::*;
#(
  parameter int PERIOD_CYC = `ABM_PERIOD_CYC,
  parameter int PERIOD_TICKS = `ABM_PERIOD_TICKS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic enable_i,
  input wire logic sleep_i,
  input wire logic rc_tick_i,
  // Measurement timing
  output logic rc_en_o,
  output logic meas_en_o,
  output logic sample_o
);

  localparam int WINDOW_CYC = `ABM_WINDOW_CYC;
  localparam int WINDOW_TICKS = `ABM_WINDOW_TICKS;

  logic [23:0] cnt_q, cnt_d;
  logic sleep_q, sleep_d;
  logic unit;
  logic [23:0] last;
  logic [23:0] win;

  // Asleep the count runs on oscillator ticks, awake on the main clock
  always_comb begin
    sleep_d = sleep_i;
    unit = sleep_i ? rc_tick_i : 1'b1;
    last = sleep_i ? 24'(PERIOD_TICKS - 1) : 24'(PERIOD_CYC - 1);
    win = sleep_i ? 24'(WINDOW_TICKS) : 24'(WINDOW_CYC);
    cnt_d = cnt_q;
    if (!enable_i || (sleep_i != sleep_q)) begin
      cnt_d = 24'h000000; // Restart so the two time bases never mix
    end else if (unit) begin
      cnt_d = (cnt_q == last) ? 24'h000000 : cnt_q + 24'h000001; // [R16]
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 24'h000000;
      sleep_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      sleep_q <= sleep_d;
    end
  end

  // Window opens at each period start, reading taken at its last unit
  assign meas_en_o = enable_i && (cnt_q < win); // [R16]
  assign sample_o = meas_en_o && unit && (cnt_q == win - 24'h000001) && (sleep_i == sleep_q);
  assign rc_en_o = enable_i && sleep_i; // [R20]

endmodule // abm_meas_timer

`default_nettype wire

// file: verilog/abm_debounce.sv
`timescale 1ns/1ps
`default_nettype none
`include "abm_defines.svh"

module abm_debounce
  import abm_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Readings
  input wire logic enable_i,
  input wire logic sample_i,
  input wire logic below_i,
  // Event
  output logic event_o
);

  logic [2:0] cnt_q, cnt_d;

  // Saturating run length of low readings, one event per low episode
  always_comb begin
    cnt_d = cnt_q;
    event_o = 1'b0;
    if (!enable_i) begin
      cnt_d = 3'h0; // [R21]
    end else if (sample_i) begin
      if (!below_i) begin
        cnt_d = 3'h0; // [R21]
      end else if (cnt_q != `ABM_LOW_COUNT) begin
        cnt_d = cnt_q + 3'h1;
        event_o = (cnt_d == `ABM_LOW_COUNT); // [R17]
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule // abm_debounce

`default_nettype wire

// file: test/abm_top_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "abm_defines.svh"

module abm_top_checker
  import abm_pkg::*;
#(
  parameter int PERIOD_CYC = `ABM_PERIOD_CYC,
  parameter int PERIOD_TICKS = `ABM_PERIOD_TICKS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Serial port and interrupt
  input wire logic spi_sck_i,
  input wire logic spi_sdi_i,
  input wire logic spi_sel_n_i,
  input wire logic spi_sdo_o,
  input wire logic irq_out_n_o,
  // Module state and analog side
  input wire logic sleep_i,
  input wire logic rc_tick_i,
  input wire logic atest_temp_i,
  input wire logic [7:0] adc_value_i,
  input wire logic [4:0] vbat_code_i,
  // Front end controls
  input wire abm_analog_t analog_o,
  input wire logic [7:0] tv_offs_o,
  input wire logic rc_en_o,
  input wire logic meas_en_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  localparam int WIN = `ABM_WINDOW_CYC;
  logic [15:0] win_q;
  logic [15:0] win_d;

  // Length of the awake window so far; asleep windows count ticks, not clocks
  always_comb begin
    win_d = (meas_en_o && !sleep_i) ? win_q + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      win_q <= 16'h0000;
    end else begin
      win_q <= win_d;
    end
  end

  // Decoded front end settings stay within the documented tables
  a_gain_table: assert property (
    !$past(rst_i) |-> analog_o.gain_num inside {8'h16, 8'h2c, 8'h42, 8'h58, 8'h21, 8'h63, 8'h84})
    else $error("gain numerator outside the table");
  a_span_match: assert property (
    !$past(rst_i) |-> ((analog_o.span_x10 == 8'ha7) == (analog_o.gain_num inside {8'h16, 8'h21}))
      && ((analog_o.span_x10 == 8'h2a) == (analog_o.gain_num inside {8'h58, 8'h84})))
    else $error("span does not match gain");
  a_offs_range: assert property (
    analog_o.offs_steps != 4'h8)
    else $error("coarse offset of minus eight steps");
  a_sensor_test: assert property (
    $past(atest_temp_i) && !$past(rst_i) |-> analog_o.ts_en)
    else $error("sensor off while routed to test bus");
  a_fahr_range: assert property (
    analog_o.ts_fahrenheit |-> analog_o.ts_lsb_milli == 11'h3e8 && analog_o.ts_low == 9'h1d8)
    else $error("fahrenheit range wrong");
  a_kelvin_range: assert property (
    analog_o.ts_absolute |-> analog_o.ts_lsb_milli == 11'h535 && analog_o.ts_low == 9'h000
      && analog_o.ts_valid)
    else $error("absolute range wrong");
  a_meas_enabled: assert property (
    sleep_i && meas_en_o |-> rc_en_o)
    else $error("asleep measurement without monitor enable");
  a_window_len: assert property (
    win_q <= 16'(WIN))
    else $error("measurement window too long");
  a_rc_asleep: assert property (
    rc_en_o |-> sleep_i)
    else $error("oscillator on while awake");
  a_sdo_idle: assert property (
    spi_sel_n_i && $past(spi_sel_n_i) |-> !spi_sdo_o)
    else $error("serial out driven while deselected");
endmodule // abm_top_checker

bind abm_top abm_top_checker #(
  .PERIOD_CYC(PERIOD_CYC),
  .PERIOD_TICKS(PERIOD_TICKS)
) i_abm_top_checker (
  .clk_i(clk_i), .rst_i(rst_i), .spi_sck_i(spi_sck_i), .spi_sdi_i(spi_sdi_i),
  .spi_sel_n_i(spi_sel_n_i), .spi_sdo_o(spi_sdo_o), .irq_out_n_o(irq_out_n_o),
  .sleep_i(sleep_i), .rc_tick_i(rc_tick_i), .atest_temp_i(atest_temp_i),
  .adc_value_i(adc_value_i), .vbat_code_i(vbat_code_i), .analog_o(analog_o),
  .tv_offs_o(tv_offs_o), .rc_en_o(rc_en_o), .meas_en_o(meas_en_o)
);

`default_nettype wire

// file: test/abm_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module abm_host_model (
  // Clock and serial return
  input wire logic clk_i,
  input wire logic sdo_i,
  // Serial lines to the device
  output logic sck_o,
  output logic sdi_o,
  output logic sel_n_o
);
  initial begin
    sck_o = 1'b0;
    sdi_o = 1'b1;
    sel_n_o = 1'b1;
  end

  // One command byte and one data byte per select; each phase lasts two clocks
  task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] wdata,
                      output logic [7:0] rdata);
    logic [15:0] frame;
    frame = {wr, addr, wdata};
    rdata = 8'h00;
    @(posedge clk_i);
    sel_n_o <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sck_o <= 1'b0;
      sdi_o <= frame[i];
      repeat (2) @(posedge clk_i);
      sck_o <= 1'b1;
      repeat (2) @(posedge clk_i);
      // Sampled at the end of the high phase, before the device shifts
      if (i < 8) rdata = {rdata[6:0], sdo_i};
    end
    sck_o <= 1'b0;
    repeat (2) @(posedge clk_i);
    sel_n_o <= 1'b1;
    sdi_o <= ~frame[0]; // Released line does not keep its last value
    repeat (2) @(posedge clk_i);
  endtask

  // Interrupt service reads both status registers
  task automatic service(output logic [7:0] st1, output logic [7:0] st2);
    xfer(1'b0, 7'h03, 8'h00, st1);
    xfer(1'b0, 7'h04, 8'h00, st2);
  endtask
endmodule // abm_host_model

`default_nettype wire

// file: test/test_abm_top.sv
`timescale 1ns/1ps
`default_nettype none

module test_abm_top;
  import abm_pkg::*;
  localparam int PCYC = 3000;
  localparam int LSB [5] = '{500, 1000, 500, 1000, 1333};
  localparam int LOW [5] = '{'h1c0, 'h1c0, 0, 'h1d8, 0};
  localparam int SPAN [4] = '{'ha7, 'h54, 'h38, 'h2a};
  logic clk_i, rst_i, sleep_i, rc_tick_i, atest_temp_i, seen;
  logic [7:0] adc_value_i, rd, s1, s2, tv_offs_o;
  logic [4:0] vbat_code_i;
  wire logic sck, sdi, sel_n, sdo, irq_out_n_o, rc_en_o, meas_en_o;
  abm_analog_t analog_o;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  int e;

  abm_top #(.PERIOD_CYC(PCYC), .PERIOD_TICKS(16)) i_abm_top (
    .clk_i(clk_i), .rst_i(rst_i), .spi_sck_i(sck), .spi_sdi_i(sdi), .spi_sel_n_i(sel_n),
    .spi_sdo_o(sdo), .irq_out_n_o(irq_out_n_o), .sleep_i(sleep_i), .rc_tick_i(rc_tick_i),
    .atest_temp_i(atest_temp_i), .adc_value_i(adc_value_i), .vbat_code_i(vbat_code_i),
    .analog_o(analog_o), .tv_offs_o(tv_offs_o), .rc_en_o(rc_en_o), .meas_en_o(meas_en_o));
  abm_host_model i_abm_host_model (
    .clk_i(clk_i), .sdo_i(sdo), .sck_o(sck), .sdi_o(sdi), .sel_n_o(sel_n));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Oscillator tick every eight clocks; timeout ends a hang
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    rc_tick_i <= (cyc % 8 == 0);
    if (cyc == 80000) begin
      err_total++;
      final_report();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [6:0] a, input logic [7:0] d);
    i_abm_host_model.xfer(1'b1, a, d, rd);
  endtask

  task automatic reg_rd(input logic [6:0] a, input logic [7:0] exp, input string what);
    i_abm_host_model.xfer(1'b0, a, 8'h00, rd);
    check(what, exp, rd);
  endtask

  // Waits for the end of one measurement window, bounded
  task automatic wait_sample();
    int n = 0;
    while (meas_en_o !== 1'b1 && n < 5000) begin
      @(posedge clk_i);
      n++;
    end
    while (meas_en_o !== 1'b0 && n < 10000) begin
      @(posedge clk_i);
      n++;
    end
    // Either loop running out means the window never came or never closed
    if (n >= 5000) begin
      check("sample wait", 0, 1);
      final_report();
    end
    repeat (2) @(posedge clk_i);
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    rst_i = 1'b1;
    sleep_i = 1'b0;
    atest_temp_i = 1'b0;
    adc_value_i = 8'h5a;
    vbat_code_i = 5'h1f;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values, read-only and unmapped places
    reg_rd(7'h12, 8'h20, "ts ctrl");
    reg_rd(7'h13, 8'h00, "tv offs");
    reg_rd(7'h1a, 8'h14, "threshold");
    reg_rd(7'h1b, 8'h00, "level");
    reg_rd(7'h7f, 8'h00, "unmapped");
    reg_wr(7'h1a, 8'hff);
    reg_rd(7'h1a, 8'h1f, "threshold width");
    reg_wr(7'h13, 8'ha5);
    check("tv_offs_o", 8'ha5, tv_offs_o);
    // Gain and span for both references
    for (int r = 0; r < 2; r++) begin
      for (int g = 0; g < 4; g++) begin
        reg_wr(7'h0f, 8'(16 + r * 4 + g));
        check("gain_num", (g + 1) * (r ? 33 : 22), analog_o.gain_num);
        check("span_x10", SPAN[g], analog_o.span_x10);
      end
    end
    check("ts_en off", 0, analog_o.ts_en);
    atest_temp_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check("ts_en test bus", 1, analog_o.ts_en);
    atest_temp_i <= 1'b0;
    // Coarse offset codes
    for (int o = 0; o < 16; o++) begin
      reg_wr(7'h10, 8'(o));
      e = o[3] ? o[2:0] : (o[2:0] == 0 ? 0 : o[2:0] - 8);
      check("offs_steps", 32'(e[3:0]), analog_o.offs_steps);
    end
    // Temperature ranges, last one with the offset disabled
    for (int k = 0; k < 5; k++) begin
      reg_wr(7'h12, k < 4 ? 8'(k * 64 + 32) : 8'h80);
      check("ts_lsb", LSB[k], analog_o.ts_lsb_milli);
      check("ts_low", LOW[k], analog_o.ts_low);
      check("ts_mode", {1'b1, k == 3, k == 4},
            {analog_o.ts_valid, analog_o.ts_fahrenheit, analog_o.ts_absolute});
    end
    reg_wr(7'h12, 8'h3a);
    check("trim", 5'h1a, {analog_o.vbg_trim_en, analog_o.vbg_trim});
    // Offset disabled outside range 10 has no defined scale
    reg_wr(7'h12, 8'h40);
    check("ts_valid off", 0, analog_o.ts_valid);
    // Temperature read sequence
    reg_wr(7'h0f, 8'h00);
    reg_wr(7'h12, 8'h20);
    check("ts_en selected", 1, analog_o.ts_en);
    reg_rd(7'h11, 8'h5a, "adc value");
    // Battery monitor: run broken by a reading at threshold
    reg_wr(7'h1a, 8'h10);
    reg_wr(7'h06, 8'h04);
    vbat_code_i <= 5'h0f;
    reg_wr(7'h07, 8'h40);
    repeat (3) wait_sample();
    vbat_code_i <= 5'h10;
    wait_sample();
    check("irq run broken", 1, irq_out_n_o);
    reg_rd(7'h1b, 8'h10, "level");
    vbat_code_i <= 5'h0f;
    repeat (3) wait_sample();
    check("irq after three", 1, irq_out_n_o);
    wait_sample();
    check("irq after four", 0, irq_out_n_o);
    reg_wr(7'h06, 8'h00);
    check("irq masked", 1, irq_out_n_o);
    reg_wr(7'h06, 8'h04);
    check("irq unmasked", 0, irq_out_n_o);
    i_abm_host_model.service(s1, s2);
    check("status pair", 16'h0004, {s1, s2});
    reg_rd(7'h04, 8'h00, "status cleared");
    check("irq cleared", 1, irq_out_n_o);
    // Disabled monitor takes no readings
    reg_wr(7'h07, 8'h00);
    seen = 1'b0;
    repeat (PCYC + 200) begin
      @(posedge clk_i);
      seen = seen | meas_en_o;
    end
    check("no window when off", 0, seen);
    // Asleep: oscillator only with the monitor on
    sleep_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    check("rc off", 0, rc_en_o);
    reg_wr(7'h07, 8'h40);
    check("rc on", 1, rc_en_o);
    vbat_code_i <= 5'h07;
    wait_sample();
    reg_rd(7'h1b, 8'h07, "level asleep");
    sleep_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check("rc awake", 0, rc_en_o);
    final_report();
  end
endmodule // test_abm_top

`default_nettype wire
